// ===== rtl/wdt_pkg.sv
// Purpose: shared constants and types for the one-time enabled watchdog
// Assumes: sys_clk is the oscillator; one machine cycle is 6 or 12 of its periods
// Notes: pulse lengths are given directly in oscillator periods
package watchdog_pkg;
    // ************************************************************
    // service port and key sequence
    // ************************************************************
    localparam logic [7:0] SERVICE_PORT_ADDR = 8'hA6;
    localparam logic [7:0] KEY_FIRST = 8'h1E;
    localparam logic [7:0] KEY_SECOND = 8'hE1;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ************************************************************
    // counter and timing
    // ************************************************************
    localparam logic [13:0] COUNT_RESET = 14'h0000;
    localparam logic [13:0] COUNT_MAX = 14'h3FFF;
    localparam logic [3:0] MC_DIV_SIX = 4'h6;
    localparam logic [3:0] MC_DIV_TWELVE = 4'hC;
    localparam logic [3:0] MC_PRESC_RESET = 4'h0;
    // reset pulse length in oscillator periods, one sys_clk cycle each
    localparam logic [7:0] PULSE_OSC_SIX = 8'h62;
    localparam logic [7:0] PULSE_OSC_TWELVE = 8'hC4;
    localparam logic [7:0] PULSE_CNT_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_PULSE
    } watchdog_state_e;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
endpackage

// ===== rtl/one_time_enabled_watchdog.sv
// Purpose: one-time enabled watchdog with reset-out pulse
// Assumes: sfr writes are single-cycle strobes synchronous to sys_clk
// Notes: sfr_rdata always reads zero; counter is invisible to software
// Behaviour
// R01: after reset the counter is idle
// R02: writing 1E then E1 to A6 arms
// R03: armed counter advances every machine cycle
// R04: no software disarm; only resets
// R05: 14-bit counter overflows at 3FFF, resets device
// R06: each key pair restarts count from zero
// R07: service port is write only
// R08: counter neither readable nor writable
// R09: overflow drives 98 or 196 period pulse
// R10: software services from periodic code paths
// R11: wrong or unpaired writes change nothing
// R12: overflow reset clears and disarms watchdog
`timescale 1ns/1ps
module one_time_enabled_watchdog
    import watchdog_pkg::*;
(
    input wire logic sys_clk, // oscillator clock, 10 MHz
    input wire logic resetn, // async reset, active low
    input wire logic twelve_clk_mode, // 1: 12 clocks per machine cycle
    input wire sfr_req_s sfr_req, // sfr write strobe, address, data
    output logic [7:0] sfr_rdata, // read data of the service port
    output logic rst_out, // high reset pulse on overflow
    output logic watchdog_active // watchdog armed
);
    // ************************************************************
    // decode
    // ************************************************************
    watchdog_state_e state_reg, state_next;
    logic [13:0] count_reg, count_next;
    logic [3:0] presc_reg, presc_next;
    logic [7:0] pulse_cnt_reg, pulse_cnt_next;
    logic pulse_long_reg, pulse_long_next;
    logic first_seen_reg, first_seen_next;
    logic rst_out_reg, rst_out_next;
    logic active_reg, active_next;
    logic [7:0] sfr_rdata_reg;
    logic port_wr;
    logic key_pair;
    logic mc_tick;
    logic [3:0] mc_div;
    logic [7:0] pulse_last;

    assign port_wr = sfr_req.wr && (sfr_req.addr == SERVICE_PORT_ADDR);
    // a pair counts only if E1 lands right after 1E on the port
    assign key_pair = port_wr && (sfr_req.wdata == KEY_SECOND) && first_seen_reg; // [R02] [R11]
    assign mc_div = twelve_clk_mode ? MC_DIV_TWELVE : MC_DIV_SIX;
    assign mc_tick = (presc_reg == (mc_div - 4'h1));
    assign pulse_last = (pulse_long_reg ? PULSE_OSC_TWELVE : PULSE_OSC_SIX) - 8'h01;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        presc_next = mc_tick ? MC_PRESC_RESET : presc_reg + 4'h1;
        pulse_cnt_next = pulse_cnt_reg;
        pulse_long_next = pulse_long_reg;
        first_seen_next = first_seen_reg;
        if (port_wr) begin
            first_seen_next = (sfr_req.wdata == KEY_FIRST); // [R11]
        end
        case (state_reg)
            ST_IDLE: begin
                count_next = COUNT_RESET; // [R01]
                if (key_pair) begin
                    state_next = ST_ARMED; // [R02]
                    presc_next = MC_PRESC_RESET;
                end
            end
            ST_ARMED: begin
                // overflow beats a service landing in the same cycle
                if (count_reg == COUNT_MAX) begin
                    state_next = ST_PULSE; // [R05]
                    count_next = COUNT_RESET;
                    pulse_cnt_next = PULSE_CNT_RESET;
                    pulse_long_next = twelve_clk_mode;
                end else if (key_pair) begin
                    count_next = COUNT_RESET; // [R06]
                    presc_next = MC_PRESC_RESET;
                end else if (mc_tick) begin
                    count_next = count_reg + 14'h0001; // [R03]
                end
                // no write path leads back to idle [R04]
            end
            ST_PULSE: begin
                first_seen_next = 1'b0;
                count_next = COUNT_RESET;
                if (pulse_cnt_reg == pulse_last) begin
                    state_next = ST_IDLE; // [R12]
                end else begin
                    pulse_cnt_next = pulse_cnt_reg + 8'h01; // [R09]
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        rst_out_next = (state_next == ST_PULSE); // [R09]
        active_next = (state_next == ST_ARMED); // [R04]
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE; // [R01]
            count_reg <= COUNT_RESET;
            presc_reg <= MC_PRESC_RESET;
            pulse_cnt_reg <= PULSE_CNT_RESET;
            pulse_long_reg <= 1'b0;
            first_seen_reg <= 1'b0;
            rst_out_reg <= 1'b0;
            active_reg <= 1'b0;
            sfr_rdata_reg <= RDATA_RESET;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            presc_reg <= presc_next;
            pulse_cnt_reg <= pulse_cnt_next;
            pulse_long_reg <= pulse_long_next;
            first_seen_reg <= first_seen_next;
            rst_out_reg <= rst_out_next;
            active_reg <= active_next;
            // reads never expose the counter or arming state
            sfr_rdata_reg <= RDATA_RESET; // [R07] [R08]
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign rst_out = rst_out_reg;
    assign watchdog_active = active_reg;

    // ************************************************************
    // checks
    // ************************************************************
    property p_idle_clear;
        @(posedge sys_clk) disable iff (!resetn)
        (state_reg == ST_IDLE) |-> (count_reg == COUNT_RESET) && !watchdog_active;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle with count"); // [R01]

    property p_arm;
        @(posedge sys_clk) disable iff (!resetn)
        (state_reg == ST_IDLE) && key_pair |=> watchdog_active && (count_reg == COUNT_RESET);
    endproperty
    a_arm: assert property (p_arm) else $error("key pair did not arm"); // [R02]

    property p_step;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && mc_tick && !key_pair && (count_reg != COUNT_MAX)
            |=> count_reg == $past(count_reg) + 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step"); // [R03]

    property p_hold;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && !mc_tick && !key_pair && (count_reg != COUNT_MAX)
            |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved between ticks"); // [R03]

    property p_tick_wrap;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && mc_tick |=> presc_reg == MC_PRESC_RESET;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("prescaler did not wrap"); // [R03]

    property p_no_disarm;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && (count_reg != COUNT_MAX) |=> watchdog_active;
    endproperty
    a_no_disarm: assert property (p_no_disarm) else $error("watchdog disarmed"); // [R04]

    property p_overflow;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && (count_reg == COUNT_MAX) |=> rst_out && !watchdog_active;
    endproperty
    a_overflow: assert property (p_overflow) else $error("no reset on overflow"); // [R05] [R12]

    property p_restart;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && key_pair && (count_reg != COUNT_MAX) |=> count_reg == COUNT_RESET;
    endproperty
    a_restart: assert property (p_restart) else $error("service did not restart"); // [R06]

    property p_service_presc;
        @(posedge sys_clk) disable iff (!resetn)
        watchdog_active && key_pair && (count_reg != COUNT_MAX) |=> presc_reg == MC_PRESC_RESET;
    endproperty
    a_service_presc: assert property (p_service_presc) else $error("phase not reset"); // [R06]

    property p_rdata_zero;
        @(posedge sys_clk) disable iff (!resetn)
        sfr_req.wr |=> sfr_rdata == RDATA_RESET;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("port read shows state"); // [R07] [R08]

    property p_pulse_six;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(rst_out) && !pulse_long_reg |-> ##97 rst_out ##1 !rst_out;
    endproperty
    a_pulse_six: assert property (p_pulse_six) else $error("short pulse length wrong"); // [R09]

    property p_pulse_twelve;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(rst_out) && pulse_long_reg |-> ##195 rst_out ##1 !rst_out;
    endproperty
    a_pulse_twelve: assert property (p_pulse_twelve) else $error("long pulse length wrong"); // [R09]

    property p_bad_key;
        @(posedge sys_clk) disable iff (!resetn)
        (state_reg == ST_IDLE) && port_wr && !first_seen_reg |=> (state_reg == ST_IDLE);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("unpaired write armed"); // [R11]

    property p_pulse_locked;
        @(posedge sys_clk) disable iff (!resetn)
        (state_reg == ST_PULSE) |=> !watchdog_active && !first_seen_reg;
    endproperty
    a_pulse_locked: assert property (p_pulse_locked) else $error("armable in pulse"); // [R12]

    property p_pulse_end;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(rst_out) |-> (state_reg == ST_IDLE) && (count_reg == COUNT_RESET);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("not idle after pulse"); // [R12]
endmodule

// ===== verif/test_one_time_enabled_watchdog.sv
// Purpose: self-checking bench for the one-time enabled watchdog
// Assumes: six-clock mode for the overflow run, about 99k cycles
// Notes: output changes are matched in order against queued notes
`timescale 1ns/1ps
module test_one_time_enabled_watchdog
    import watchdog_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic twelve_clk_mode = 1'b0;
    sfr_req_s sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic rst_out;
    logic watchdog_active;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int last_cyc = 0;
    logic [1:0] prev_seen = 2'b00;
    logic [1:0] exp_val[$];
    int exp_at[$];

    always #50 sys_clk = ~sys_clk;

    one_time_enabled_watchdog one_time_enabled_watchdog_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .twelve_clk_mode(twelve_clk_mode),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .rst_out(rst_out),
        .watchdog_active(watchdog_active)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one strobe, then an idle cycle so the task is never re-entered on its release edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        last_cyc = cyc;
        sfr_req <= '{wr: 1'b1, addr: addr, wdata: data};
        @(posedge sys_clk);
        sfr_req <= '{wr: 1'b0, addr: addr, wdata: ~data};
    endtask

    task automatic expect_at(input logic [1:0] v, input int at);
        exp_val.push_back(v);
        exp_at.push_back(at);
    endtask

    task automatic wait_drain(input int limit);
        for (int i = 0; i < limit && exp_val.size() != 0; i++) begin
            @(posedge sys_clk);
        end
        check("pending events", exp_val.size(), 0);
    endtask

    // ************************************************************
    // monitor: {rst_out, watchdog_active} changes, sampled mid-cycle
    // ************************************************************
    always @(negedge sys_clk) begin
        cyc = cyc + 1;
        if ({rst_out, watchdog_active} !== prev_seen) begin
            if (exp_val.size() == 0) begin
                check("unexpected change", {rst_out, watchdog_active}, prev_seen);
            end else begin
                check("outputs", {rst_out, watchdog_active}, exp_val.pop_front());
                check("event cycle", cyc, exp_at.pop_front());
            end
            check("port read", sfr_rdata, RDATA_RESET);
        end
        prev_seen = {rst_out, watchdog_active};
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int gap;
        logic [7:0] junk;
        void'($urandom(71));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        junk = 8'($urandom_range(32'hE0, 32'h1F));
        // only the last E1 may arm: writes to other addresses leave the earlier 1E pending
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        wr(SERVICE_PORT_ADDR, KEY_FIRST);
        wr(SERVICE_PORT_ADDR, junk);
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        wr(SERVICE_PORT_ADDR, KEY_FIRST);
        wr(8'hA7, KEY_SECOND);
        wr({1'b0, junk[6:0]}, junk);
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        expect_at(2'b01, last_cyc + 2);
        // stray writes while armed: no disarm, no restart
        wr(SERVICE_PORT_ADDR, junk);
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        gap = $urandom_range(600, 100);
        repeat (gap) @(posedge sys_clk);
        // service well inside the overflow interval
        wr(SERVICE_PORT_ADDR, KEY_FIRST);
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        // 16383 machine cycles of six clocks, then the pulse
        expect_at(2'b10, last_cyc + 2 + 98299);
        expect_at(2'b00, last_cyc + 2 + 98299 + 98);
        wait_drain(99000);
        twelve_clk_mode <= 1'b1;
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        wr(SERVICE_PORT_ADDR, KEY_FIRST);
        wr(SERVICE_PORT_ADDR, KEY_SECOND);
        expect_at(2'b01, last_cyc + 2);
        repeat (50) @(posedge sys_clk);
        resetn <= 1'b0;
        expect_at(2'b00, cyc + 1);
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        wait_drain(10);
        repeat (20) @(posedge sys_clk);
        report_and_stop();
    end

    // hang guard, a little past the longest expected run
    initial begin
        #(105000 * 100);
        miscompares++;
        report_and_stop();
    end
endmodule
